// file: ncofw_pkg.sv
package ncofw_pkg;
    localparam int ADDR_W = 12;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int NUM_BAND1_OSC = 3;
    localparam logic [11:0] DUAL_BAND_ADDR = 12'h002;
    localparam logic [11:0] OSC1_FREQ_LOW_ADDR = 12'h007;
    localparam logic [11:0] OSC1_FREQ_HIGH_ADDR = 12'h008;
    localparam logic [11:0] OSC2_FREQ_LOW_ADDR = 12'h009;
    localparam logic [11:0] OSC2_FREQ_HIGH_ADDR = 12'h00a;
    localparam logic [11:0] OSC3_FREQ_LOW_ADDR = 12'h00b;
    localparam logic [11:0] OSC3_FREQ_HIGH_ADDR = 12'h00c;
    localparam logic [11:0] BAND2_OSC_FREQ_LOW_ADDR = 12'h00d;
    localparam logic [11:0] BAND2_OSC_FREQ_HIGH_ADDR = 12'h00e;
    localparam logic [11:0] OSC_SELECT_SOURCE_ADDR = 12'h00f;
    localparam logic [11:0] OSC_SELECT_FIELD_ADDR = 12'h010;
    localparam int DUAL_BAND_EN_BIT = 0;
    localparam int SEL_BY_PINS_BIT = 0;
    localparam int SEL_FIELD_LSB = 0;
    localparam int SEL_FIELD_W = 2;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [1:0] SEL_RESET = 2'h0;
    typedef enum logic [1:0] {
        NCOFW_SEL_OSC1 = 2'b00,
        NCOFW_SEL_OSC2 = 2'b01,
        NCOFW_SEL_OSC3 = 2'b10,
        NCOFW_SEL_NONE = 2'b11
    } ncofw_sel_e;
endpackage

// file: ncofw_word_reg.sv
`timescale 1ns/1ps
`default_nettype none
module ncofw_word_reg #(
    parameter logic [11:0] LOW_ADDR = 12'h000,
    parameter int WORD_W = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [WORD_W-1:0] word_o,
    output logic hit_o,
    output logic [7:0] rdata_o
);
    localparam logic [11:0] HIGH_ADDR = LOW_ADDR + 12'h001;

    logic [WORD_W-1:0] word_reg;

    // low byte at the lower address, high byte at the next
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_reg <= ncofw_pkg::WORD_RESET;
        end else if (wr_i && addr_i == LOW_ADDR) begin
            word_reg[7:0] <= wdata_i;
        end else if (wr_i && addr_i == HIGH_ADDR) begin
            word_reg[15:8] <= wdata_i;
        end
    end

    always_comb begin
        hit_o = (addr_i == LOW_ADDR) || (addr_i == HIGH_ADDR);
        if (addr_i == HIGH_ADDR) begin
            rdata_o = word_reg[15:8];
        end else if (addr_i == LOW_ADDR) begin
            rdata_o = word_reg[7:0];
        end else begin
            rdata_o = ncofw_pkg::BYTE_RESET;
        end
    end

    assign word_o = word_reg;
endmodule
`default_nettype wire

// file: ncofw_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ncofw_regs #(
    parameter int WORD_W = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [1:0] osc_sel_pins_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [WORD_W-1:0] band1_freq_word_o,
    output logic [1:0] band1_osc_active_o,
    output logic [WORD_W-1:0] band2_freq_word_o,
    output logic dual_band_o
);
    logic [WORD_W-1:0] word_w [0:3];
    logic [7:0] byte_w [0:3];
    logic [3:0] hit_w;
    logic dual_band_reg;
    logic dual_band_next;
    logic [WORD_W-1:0] band1_word_next;
    logic osc_select_by_pins_reg;
    logic [1:0] osc_select_field_reg;
    logic [1:0] active_reg;
    logic [1:0] active_next;
    logic [WORD_W-1:0] band1_word_reg;
    logic [WORD_W-1:0] band2_word_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;

    localparam logic [11:0] LOW_ADDRS [0:3] = '{
        ncofw_pkg::OSC1_FREQ_LOW_ADDR,
        ncofw_pkg::OSC2_FREQ_LOW_ADDR,
        ncofw_pkg::OSC3_FREQ_LOW_ADDR,
        ncofw_pkg::BAND2_OSC_FREQ_LOW_ADDR
    };

    // words 0..2 are band 1, word 3 is band 2
    for (genvar g = 0; g < 4; g++) begin : g_word
        ncofw_word_reg #(
            .LOW_ADDR(LOW_ADDRS[g]),
            .WORD_W(WORD_W)
        ) u_word (
            .sys_clk_i(sys_clk_i),
            .rst_n_i(rst_n_i),
            .wr_i(wr_i),
            .addr_i(addr_i),
            .wdata_i(wdata_i),
            .word_o(word_w[g]),
            .hit_o(hit_w[g]),
            .rdata_o(byte_w[g])
        );
    end

    // band 2 gating follows the bit on the same edge, so no stale word
    // leaks out in the cycle after dual-band is switched off
    always_comb begin
        dual_band_next = dual_band_reg;
        if (wr_i && addr_i == ncofw_pkg::DUAL_BAND_ADDR) begin
            dual_band_next = wdata_i[ncofw_pkg::DUAL_BAND_EN_BIT];
        end
    end

    // must-write-zero bits are dropped on write and read back as zero
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dual_band_reg <= 1'b0;
        end else begin
            dual_band_reg <= dual_band_next;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_select_by_pins_reg <= 1'b0;
        end else if (wr_i && addr_i == ncofw_pkg::OSC_SELECT_SOURCE_ADDR) begin
            osc_select_by_pins_reg <= wdata_i[ncofw_pkg::SEL_BY_PINS_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_select_field_reg <= ncofw_pkg::SEL_RESET;
        end else if (wr_i && addr_i == ncofw_pkg::OSC_SELECT_FIELD_ADDR) begin
            osc_select_field_reg <= wdata_i[ncofw_pkg::SEL_FIELD_LSB +:
                                            ncofw_pkg::SEL_FIELD_W];
        end
    end

    // code 11 has no oscillator, so the last valid choice is kept
    always_comb begin
        logic [1:0] choice;
        choice = osc_sel_pins_i;
        if (!osc_select_by_pins_reg) begin
            choice = osc_select_field_reg;
        end
        case (choice)
            ncofw_pkg::NCOFW_SEL_OSC1: active_next = 2'h0;
            ncofw_pkg::NCOFW_SEL_OSC2: active_next = 2'h1;
            ncofw_pkg::NCOFW_SEL_OSC3: active_next = 2'h2;
            default: active_next = active_reg;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_reg <= 2'h0;
        end else begin
            active_reg <= active_next;
        end
    end

    // explicit decode keeps the band 2 word out of the band 1 path
    always_comb begin
        case (active_next)
            2'h0: band1_word_next = word_w[0];
            2'h1: band1_word_next = word_w[1];
            2'h2: band1_word_next = word_w[2];
            default: band1_word_next = word_w[0];
        endcase
    end

    // word is used byte by byte, so a half-written word may show briefly
    // lsb weight is fs / 2**16 downstream; no scaling here
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            band1_word_reg <= ncofw_pkg::WORD_RESET;
        end else begin
            band1_word_reg <= band1_word_next;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            band2_word_reg <= ncofw_pkg::WORD_RESET;
        end else if (dual_band_next) begin
            band2_word_reg <= word_w[3];
        end else begin
            band2_word_reg <= ncofw_pkg::WORD_RESET;
        end
    end

    always_comb begin
        rdata_next = ncofw_pkg::BYTE_RESET;
        for (int i = 0; i < 4; i++) begin
            if (hit_w[i]) begin
                rdata_next = byte_w[i];
            end
        end
        if (addr_i == ncofw_pkg::DUAL_BAND_ADDR) begin
            rdata_next = {7'h00, dual_band_reg};
        end
        if (addr_i == ncofw_pkg::OSC_SELECT_SOURCE_ADDR) begin
            rdata_next = {7'h00, osc_select_by_pins_reg};
        end
        if (addr_i == ncofw_pkg::OSC_SELECT_FIELD_ADDR) begin
            rdata_next = {6'h00, osc_select_field_reg};
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= ncofw_pkg::BYTE_RESET;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= rd_i;
            if (rd_i) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign rdata_o = rdata_reg;
    assign rvalid_o = rvalid_reg;
    assign band1_freq_word_o = band1_word_reg;
    assign band1_osc_active_o = active_reg;
    assign band2_freq_word_o = band2_word_reg;
    assign dual_band_o = dual_band_reg;
endmodule
`default_nettype wire

// file: ncofw_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ncofw_regs_chk #(
    parameter int WORD_W = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [1:0] osc_sel_pins_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic [WORD_W-1:0] band1_freq_word_o,
    input wire logic [1:0] band1_osc_active_o,
    input wire logic [WORD_W-1:0] band2_freq_word_o,
    input wire logic dual_band_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // shadow of the source bit and field, updated on the same edge as storage
    logic src_q;
    logic [1:0] fld_q;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_q <= 1'b0;
            fld_q <= 2'h0;
        end else if (wr_i) begin
            if (addr_i == 12'h00f) src_q <= wdata_i[0];
            if (addr_i == 12'h010) fld_q <= wdata_i[1:0];
        end
    end
    rd_answer_a: assert property (rd_i |=> rvalid_o) else $error("no rvalid");
    rvalid_pulse_a: assert property (!rd_i |=> !rvalid_o) else $error("stray rvalid");
    rdata_hold_a: assert property (!rd_i |=> $stable(rdata_o)) else $error("rdata moved");
    unmapped_zero_a: assert property (rd_i && addr_i == 12'h0ff |=> rdata_o == 8'h00) else $error("unmapped not 0");
    band2_gate_a: assert property (!dual_band_o |-> band2_freq_word_o == '0) else $error("band2 not gated");
    active_code_a: assert property (band1_osc_active_o != 2'b11) else $error("bad active");
    dual_write_a: assert property (wr_i && addr_i == 12'h002 |=> ##1 dual_band_o == $past(wdata_i[0], 2)) else $error("dual bit");
    pin_select_a: assert property (src_q && osc_sel_pins_i != 2'b11 |=> band1_osc_active_o == $past(osc_sel_pins_i)) else $error("pin sel");
    field_select_a: assert property (!src_q && fld_q != 2'b11 |=> band1_osc_active_o == $past(fld_q)) else $error("field sel");
    cover property (src_q && osc_sel_pins_i == 2'b10);
    cover property ($rose(dual_band_o));
    cover property (rd_i && addr_i == 12'h0ff);
endmodule
bind ncofw_regs ncofw_regs_chk #(.WORD_W(WORD_W)) chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .osc_sel_pins_i(osc_sel_pins_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .dual_band_o(dual_band_o),
    .band1_freq_word_o(band1_freq_word_o), .band2_freq_word_o(band2_freq_word_o),
    .band1_osc_active_o(band1_osc_active_o));
`default_nettype wire

// file: tb_ncofw_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb_ncofw_regs;
    logic sys_clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, rvalid_o, dual_band_o;
    logic [11:0] addr_i = 12'h000;
    logic [7:0] wdata_i = 8'h00, rdata_o;
    logic [1:0] osc_sel_pins_i = 2'h0, band1_osc_active_o;
    logic [15:0] band1_freq_word_o, band2_freq_word_o;
    int n_mismatch = 0, checks_done = 0;
    logic [7:0] mem [0:31];
    always #20 sys_clk_i = ~sys_clk_i;
    ncofw_regs dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i),
        .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .osc_sel_pins_i(osc_sel_pins_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .band1_freq_word_o(band1_freq_word_o), .dual_band_o(dual_band_o),
        .band1_osc_active_o(band1_osc_active_o),
        .band2_freq_word_o(band2_freq_word_o));
    // writable bits per address; everything else reads back 0
    function automatic logic [7:0] msk(input logic [11:0] a);
        if (a >= 12'h007 && a <= 12'h00e) return 8'hff;
        if (a == 12'h002 || a == 12'h00f) return 8'h01;
        if (a == 12'h010) return 8'h03;
        return 8'h00;
    endfunction
    task automatic print_verdict();
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        wr_i = 1; addr_i = a; wdata_i = d;
        if (a < 12'h020) mem[a[4:0]] = d & msk(a);
        @(negedge sys_clk_i);
        wr_i = 0;
    endtask
    task automatic rd(input logic [11:0] a);
        int i;
        @(negedge sys_clk_i);
        rd_i = 1; addr_i = a;
        @(negedge sys_clk_i);
        rd_i = 0;
        for (i = 0; i < 4 && rvalid_o !== 1'b1; i++) @(negedge sys_clk_i);
        if (i == 4) begin n_mismatch++; print_verdict(); end
        `CHK(rdata_o, (a < 12'h020) ? mem[a[4:0]] : 8'h00)
    endtask
    task automatic chk_sel(input logic [1:0] s);
        repeat (2) @(negedge sys_clk_i);
        `CHK(band1_osc_active_o, s)
        `CHK(band1_freq_word_o, {mem[8 + 2 * s], mem[7 + 2 * s]})
    endtask
    initial begin
        int k;
        void'($urandom(32'h7e60));
        for (k = 0; k < 32; k++) mem[k] = 8'h00;
        repeat (12) @(posedge sys_clk_i);
        @(negedge sys_clk_i) rst_n_i = 1;
        for (k = 2; k < 17; k++) rd(k[11:0]);
        for (k = 2; k < 17; k++) wr(k[11:0], 8'($urandom) | 8'h80);
        for (k = 2; k < 17; k++) rd(k[11:0]);
        wr(12'h0ff, 8'hff);
        rd(12'h0ff);
        wr(12'h00f, 8'h00);
        for (k = 0; k < 3; k++) begin
            wr(12'h010, k[7:0]);
            chk_sel(k[1:0]);
        end
        wr(12'h010, 8'h03);
        chk_sel(2'h2);
        wr(12'h00f, 8'h01);
        for (k = 0; k < 3; k++) begin
            osc_sel_pins_i = k[1:0];
            chk_sel(k[1:0]);
        end
        osc_sel_pins_i = 2'h3;
        chk_sel(2'h2);
        for (k = 0; k < 3; k++) begin
            wr(12'h002, k[7:0]);
            repeat (2) @(negedge sys_clk_i);
            `CHK(dual_band_o, k[0])
            `CHK(band2_freq_word_o, k[0] ? {mem[14], mem[13]} : 16'h0000)
        end
        print_verdict();
    end
endmodule
`default_nettype wire
